// *** hdl/mpfc_consts.svh ***
// offsets, field positions, reset values for the pin setup block
`ifndef MPFC_CONSTS_SVH
`define MPFC_CONSTS_SVH
`define MPFC_ADDR_W        8
`define MPFC_OFS_TRDY      8'h2C
`define MPFC_OFS_SRDY      8'h2D
`define MPFC_OFS_DATA      8'h2E
`define MPFC_OFS_PINSTAT   8'h40
`define MPFC_OFS_GPIO_OUT  8'h41
`define MPFC_RST_SETUP     8'h00
`define MPFC_BIT_PU        7
`define MPFC_BIT_PD        6
`define MPFC_BIT_RX_WAKE   5
`define MPFC_BIT_TX_PP     0
`define MPFC_TRDY_RSV_MASK 8'h38
`define MPFC_SRDY_RSV_MASK 8'h3C
`define MPFC_DATA_RSV_MASK 8'h1E
`endif

// *** hdl/mpfc_pkg.sv ***
// types for the pin setup block
package mpfc_pkg;
  typedef enum logic [2:0] {
    MPFC_TRDY_GPIO_IN  = 3'h0,
    MPFC_TRDY_GPIO_OD  = 3'h1,
    MPFC_TRDY_GPIO_PP  = 3'h2,
    MPFC_TRDY_MODEM_OD = 3'h3,
    MPFC_TRDY_MODEM_PP = 3'h4
  } mpfc_trdy_fn_t;
  typedef enum logic [1:0] {
    MPFC_SRDY_GPIO_IN = 2'h0,
    MPFC_SRDY_GPIO_OD = 2'h1,
    MPFC_SRDY_GPIO_PP = 2'h2
  } mpfc_srdy_fn_t;
endpackage

// *** hdl/mpfc_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mpfc_sync (
  input  wire logic       i_clk,   // core clock
  input  wire logic       i_nrst,  // async reset, active low
  input  wire logic [2:0] i_async, // raw pin levels
  output logic      [2:0] o_sync   // synchronised levels
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
  } mpfc_sync_st_t;
  mpfc_sync_st_t s_q, s_d;
  always_comb begin
    s_d      = s_q;
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // lines idle high; a zero here fakes a receive edge after reset
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_sync = s_q.sync;
endmodule // mpfc_sync
`default_nettype wire

// *** hdl/mpfc_pad.sv ***
// pad control for one configurable pin: drive, enable, pulls
`timescale 1ns/1ps
`default_nettype none
module mpfc_pad (
  input  wire logic i_is_out, // pin set up as output
  input  wire logic i_od,     // open-drain driver
  input  wire logic i_val,    // value to present
  input  wire logic i_pu,     // pull-up bit
  input  wire logic i_pd,     // pull-down bit
  output logic      o_out,    // pad output level
  output logic      o_oe_n,   // pad enable, low = driving
  output logic      o_pu,     // pull-up connect
  output logic      o_pd      // pull-down connect
);
  // open drain only ever drives low; a one releases the wire
  assign o_out  = i_od ? 1'b0 : i_val;
  assign o_oe_n = !(i_is_out && !(i_od && i_val));
  // pulls only for inputs, and pull-up wins
  assign o_pu   = !i_is_out && i_pu;
  assign o_pd   = !i_is_out && i_pd && !i_pu;
endmodule // mpfc_pad
`default_nettype wire

// *** hdl/mpfc_top.sv ***
// pin function setup for terminal-ready, set-ready and serial data pins
// Behaviour
// [RULE_01] pull-up bit 7 of modem pins acts only while the pin is input
// [RULE_02] pull-down bit 6 acts only as input and with pull-up clear
// [RULE_03] terminal-ready field 2:0: 000 input, 001 open drain, 010 push-pull
// [RULE_04] codes 011 and 100 drive modem DTR open drain or push-pull
// [RULE_05] software never writes terminal-ready codes 101 to 111
// [RULE_06] DTR use needs set-ready as input and other modem pins as GPIO
// [RULE_07] set-ready field 1:0: 00 input, 01 open drain, 10 push-pull
// [RULE_08] software never writes set-ready code 11
// [RULE_09] software writes zero into reserved bits of all three registers
// [RULE_10] data register bit 7 connects receive pin pull-up
// [RULE_11] bit 6 connects receive pull-down unless bit 7 is also set
// [RULE_12] receive activity wakes host only with bit 5 and global enable
// [RULE_13] data bit 0 picks transmit driver: 0 open drain, 1 push-pull
// [RULE_14] open drain pulls low for zero and releases for one
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mpfc_consts.svh"
module mpfc_top (
  input  wire logic       i_clk,         // core clock, 25 MHz
  input  wire logic       i_nrst,        // async reset, active low
  input  wire logic [7:0] i_addr,        // register address
  input  wire logic [7:0] i_wdata,       // write data
  input  wire logic       i_wr,          // write strobe
  input  wire logic       i_rd,          // read strobe
  output logic      [7:0] o_rdata,       // read data, cycle after strobe
  input  wire logic       i_otp_load,    // load setups from otp image
  input  wire logic [7:0] i_otp_trdy,    // otp terminal-ready setup
  input  wire logic [7:0] i_otp_srdy,    // otp set-ready setup
  input  wire logic [7:0] i_otp_data,    // otp data pin setup
  input  wire logic       i_dtr,         // modem dtr level from uart
  input  wire logic       i_txd,         // transmit data from uart
  input  wire logic       i_rwk_global,  // device remote wakeup enable
  input  wire logic       i_suspended,   // bus in suspend
  input  wire logic       i_trdy_in,     // terminal-ready pin level
  input  wire logic       i_srdy_in,     // set-ready pin level
  input  wire logic       i_rxd_in,      // receive data pin level
  output logic            o_trdy_out,    // terminal-ready pad output
  output logic            o_trdy_oe_n,   // terminal-ready enable, low
  output logic            o_trdy_pu,     // terminal-ready pull-up
  output logic            o_trdy_pd,     // terminal-ready pull-down
  output logic            o_srdy_out,    // set-ready pad output
  output logic            o_srdy_oe_n,   // set-ready enable, low
  output logic            o_srdy_pu,     // set-ready pull-up
  output logic            o_srdy_pd,     // set-ready pull-down
  output logic            o_rxd_pu,      // receive pin pull-up
  output logic            o_rxd_pd,      // receive pin pull-down
  output logic            o_txd_out,     // transmit pad output
  output logic            o_txd_oe_n,    // transmit enable, low
  output logic            o_rxd_sync,    // synchronised receive data
  output logic            o_dsr,         // synchronised dsr to uart
  output logic            o_wake         // remote wakeup request pulse
);
  import mpfc_pkg::*;

  typedef struct packed {
    logic [7:0] trdy;
    logic [7:0] srdy;
    logic [7:0] data;
    logic [1:0] gpio_out;
    logic [7:0] rdata;
    logic       rxd_last;
    logic       wake;
  } mpfc_st_t;

  mpfc_st_t   s_q, s_d;
  logic [2:0] pins_sync;
  logic       trdy_out_sel, trdy_od, trdy_val;
  logic       srdy_out_sel, srdy_od;
  logic       rxd_s;

  function automatic logic [7:0] mpfc_clean(input logic [7:0] v,
                                            input logic [7:0] rsv);
    mpfc_clean = v & ~rsv;
  endfunction

  mpfc_sync u_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async ({i_rxd_in, i_srdy_in, i_trdy_in}),
    .o_sync  (pins_sync)
  );
  assign rxd_s = pins_sync[2];

  // decode of the terminal-ready function field
  always_comb begin
    trdy_out_sel = 1'b0;
    trdy_od      = 1'b0;
    trdy_val     = s_q.gpio_out[0];
    case (mpfc_trdy_fn_t'(s_q.trdy[2:0]))
      MPFC_TRDY_GPIO_IN: begin // RULE_03
        trdy_out_sel = 1'b0;
      end
      MPFC_TRDY_GPIO_OD: begin // RULE_03
        trdy_out_sel = 1'b1;
        trdy_od      = 1'b1;
      end
      MPFC_TRDY_GPIO_PP: begin // RULE_03
        trdy_out_sel = 1'b1;
      end
      MPFC_TRDY_MODEM_OD: begin // RULE_04
        trdy_out_sel = 1'b1;
        trdy_od      = 1'b1;
        trdy_val     = i_dtr;
      end
      MPFC_TRDY_MODEM_PP: begin // RULE_04
        trdy_out_sel = 1'b1;
        trdy_val     = i_dtr;
      end
      default: begin
        // invalid codes: keep the pin an input so nothing fights the wire
        trdy_out_sel = 1'b0;
      end
    endcase
  end

  always_comb begin
    srdy_out_sel = 1'b0;
    srdy_od      = 1'b0;
    case (mpfc_srdy_fn_t'(s_q.srdy[1:0]))
      MPFC_SRDY_GPIO_IN: srdy_out_sel = 1'b0; // RULE_07
      MPFC_SRDY_GPIO_OD: begin // RULE_07
        srdy_out_sel = 1'b1;
        srdy_od      = 1'b1;
      end
      MPFC_SRDY_GPIO_PP: srdy_out_sel = 1'b1; // RULE_07
      default:           srdy_out_sel = 1'b0;
    endcase
  end

  mpfc_pad u_trdy (
    .i_is_out (trdy_out_sel),
    .i_od     (trdy_od),
    .i_val    (trdy_val),
    .i_pu     (s_q.trdy[`MPFC_BIT_PU]),
    .i_pd     (s_q.trdy[`MPFC_BIT_PD]),
    .o_out    (o_trdy_out),
    .o_oe_n   (o_trdy_oe_n),
    .o_pu     (o_trdy_pu), // RULE_01
    .o_pd     (o_trdy_pd)  // RULE_02
  );

  mpfc_pad u_srdy (
    .i_is_out (srdy_out_sel),
    .i_od     (srdy_od),
    .i_val    (s_q.gpio_out[1]),
    .i_pu     (s_q.srdy[`MPFC_BIT_PU]),
    .i_pd     (s_q.srdy[`MPFC_BIT_PD]),
    .o_out    (o_srdy_out),
    .o_oe_n   (o_srdy_oe_n),
    .o_pu     (o_srdy_pu), // RULE_01
    .o_pd     (o_srdy_pd)  // RULE_02
  );

  // receive pin is always an input, so its pull bits always apply and pull-up wins
  mpfc_pad u_rxd (
    .i_is_out (1'b0),
    .i_od     (1'b0),
    .i_val    (1'b0),
    .i_pu     (s_q.data[`MPFC_BIT_PU]),
    .i_pd     (s_q.data[`MPFC_BIT_PD]),
    .o_out    (),
    .o_oe_n   (),
    .o_pu     (o_rxd_pu), // RULE_10
    .o_pd     (o_rxd_pd)  // RULE_11
  );

  // transmit pin is always an output
  mpfc_pad u_txd (
    .i_is_out (1'b1),
    .i_od     (!s_q.data[`MPFC_BIT_TX_PP]), // RULE_13
    .i_val    (i_txd),
    .i_pu     (1'b0),
    .i_pd     (1'b0),
    .o_out    (o_txd_out),
    .o_oe_n   (o_txd_oe_n), // RULE_14
    .o_pu     (),
    .o_pd     ()
  );

  always_comb begin
    s_d          = s_q;
    s_d.rxd_last = rxd_s;
    // any receive edge while suspended counts as wake activity
    s_d.wake     = i_suspended && (rxd_s != s_q.rxd_last) &&
                   s_q.data[`MPFC_BIT_RX_WAKE] && i_rwk_global; // RULE_12
    if (i_otp_load) begin
      // reserved bits are forced to zero so reads stay clean
      s_d.trdy = mpfc_clean(i_otp_trdy, `MPFC_TRDY_RSV_MASK);
      s_d.srdy = mpfc_clean(i_otp_srdy, `MPFC_SRDY_RSV_MASK);
      s_d.data = mpfc_clean(i_otp_data, `MPFC_DATA_RSV_MASK);
    end else if (i_wr) begin
      case (i_addr)
        `MPFC_OFS_TRDY:
          s_d.trdy = mpfc_clean(i_wdata, `MPFC_TRDY_RSV_MASK);
        `MPFC_OFS_SRDY:
          s_d.srdy = mpfc_clean(i_wdata, `MPFC_SRDY_RSV_MASK);
        `MPFC_OFS_DATA:
          s_d.data = mpfc_clean(i_wdata, `MPFC_DATA_RSV_MASK);
        `MPFC_OFS_GPIO_OUT:
          s_d.gpio_out = i_wdata[1:0];
        default: s_d.gpio_out = s_q.gpio_out;
      endcase
    end
    s_d.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `MPFC_OFS_TRDY:     s_d.rdata = s_q.trdy;
        `MPFC_OFS_SRDY:     s_d.rdata = s_q.srdy;
        `MPFC_OFS_DATA:     s_d.rdata = s_q.data;
        `MPFC_OFS_PINSTAT:  s_d.rdata = {5'h00, pins_sync};
        `MPFC_OFS_GPIO_OUT: s_d.rdata = {6'h00, s_q.gpio_out};
        default:            s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q          <= '0;
      s_q.rxd_last <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata    = s_q.rdata;
  assign o_wake     = s_q.wake;
  assign o_rxd_sync = rxd_s;
  assign o_dsr      = pins_sync[1];

  a_trdy_pull_out: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.trdy[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4}) |->
    (!o_trdy_pu && !o_trdy_pd))
    else $error("pull active on output pin"); // RULE_01
  a_trdy_pull_in: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.trdy[2:0] == 3'h0) |->
    (o_trdy_pu == s_q.trdy[7]) && (o_trdy_pd == (s_q.trdy[6] && !s_q.trdy[7])))
    else $error("input pull wrong"); // RULE_02
  a_srdy_pull: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_srdy_pd |-> !o_srdy_pu && s_q.srdy[1:0] == 2'h0))
    else $error("set-ready pull-down wrong"); // RULE_02
  a_trdy_pp_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.trdy[2:0] == 3'h4) |-> (!o_trdy_oe_n && o_trdy_out == i_dtr))
    else $error("dtr push-pull wrong"); // RULE_04
  a_trdy_in_float: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.trdy[2:0] == 3'h0) |-> o_trdy_oe_n)
    else $error("input pin driven"); // RULE_03
  a_srdy_od_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.srdy[1:0] == 2'h1) |->
    (o_srdy_oe_n == s_q.gpio_out[1]) && !o_srdy_out)
    else $error("set-ready open drain wrong"); // RULE_07
  a_rxd_pulls: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_rxd_pu == s_q.data[7]) && (o_rxd_pd == (s_q.data[6] && !s_q.data[7])))
    else $error("receive pulls wrong"); // RULE_11
  a_wake_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_wake |-> $past(s_q.data[5]) && $past(i_rwk_global))
    else $error("wake without enables"); // RULE_12
  a_tx_od_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !s_q.data[0] |-> (o_txd_oe_n == i_txd) && !o_txd_out)
    else $error("transmit open drain wrong"); // RULE_14
  a_tx_pp_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s_q.data[0] |-> !o_txd_oe_n && (o_txd_out == i_txd))
    else $error("transmit push-pull wrong"); // RULE_13
endmodule // mpfc_top
`default_nettype wire

// *** test/mpfc_line_model.sv ***
// far-side line model: resolves pad drive, pulls and external driver
`timescale 1ns/1ps
`default_nettype none
module mpfc_line_model (
  input  wire logic i_clk,    // core clock, paces the float pattern
  input  wire logic i_out,    // pad output level
  input  wire logic i_oe_n,   // pad enable, low = driving
  input  wire logic i_pu,     // pull-up connect
  input  wire logic i_pd,     // pull-down connect
  input  wire logic i_ext_en, // far side drives the line
  input  wire logic i_ext,    // far side level
  output logic      o_lvl     // resolved line level
);
  logic flip = 1'b0;
  always @(posedge i_clk) flip <= ~flip;
  always_comb begin
    if (!i_oe_n) o_lvl = i_out;
    else if (i_ext_en) o_lvl = i_ext;
    else if (i_pu) o_lvl = 1'b1;
    else if (i_pd) o_lvl = 1'b0;
    else o_lvl = flip; // floating line never holds a clean level
  end
endmodule // mpfc_line_model
`default_nettype wire

// *** test/modem_pin_function_config_tb.sv ***
// self-checking bench for the pin setup block
`timescale 1ns/1ps
`default_nettype none
module modem_pin_function_config_tb;
  logic       i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_otp_load = 0;
  logic       i_dtr = 0, i_txd = 0, i_rwk_global = 0, i_suspended = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, i_otp_trdy = 0, i_otp_srdy = 0;
  logic [7:0] i_otp_data = 0, o_rdata, d;
  logic       t_out, t_oe, t_pu, t_pd, s_out, s_oe, s_pu, s_pd, x_out, x_oe;
  logic       r_pu, r_pd, t_lvl, s_lvl, r_lvl, rx_ext = 1, o_wake;
  logic       o_dsr, o_rxd_sync, s_xen = 0, s_xv = 0;
  int         n_errors = 0, num_checks = 0;
  logic [7:0] tv[7] = '{8'hC3, 8'hC4, 8'h40, 8'h80, 8'hC0, 8'hC1, 8'hC2};
  logic [7:0] xv[5] = '{8'h00, 8'h01, 8'h40, 8'h80, 8'hC1};
  always #20 i_clk = ~i_clk;
  mpfc_top i_mpfc_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_otp_load(i_otp_load), .i_otp_trdy(i_otp_trdy),
    .i_otp_srdy(i_otp_srdy), .i_otp_data(i_otp_data), .i_dtr(i_dtr),
    .i_txd(i_txd), .i_rwk_global(i_rwk_global), .i_suspended(i_suspended),
    .i_trdy_in(t_lvl), .i_srdy_in(s_lvl), .i_rxd_in(r_lvl),
    .o_trdy_out(t_out), .o_trdy_oe_n(t_oe), .o_trdy_pu(t_pu),
    .o_trdy_pd(t_pd), .o_srdy_out(s_out), .o_srdy_oe_n(s_oe),
    .o_srdy_pu(s_pu), .o_srdy_pd(s_pd), .o_rxd_pu(r_pu), .o_rxd_pd(r_pd),
    .o_txd_out(x_out), .o_txd_oe_n(x_oe), .o_rxd_sync(o_rxd_sync),
    .o_dsr(o_dsr), .o_wake(o_wake));
  mpfc_line_model i_mpfc_line_model_t (.i_clk(i_clk), .i_out(t_out),
    .i_oe_n(t_oe), .i_pu(t_pu), .i_pd(t_pd), .i_ext_en(1'b0),
    .i_ext(1'b0), .o_lvl(t_lvl));
  mpfc_line_model i_mpfc_line_model_s (.i_clk(i_clk), .i_out(s_out),
    .i_oe_n(s_oe), .i_pu(s_pu), .i_pd(s_pd), .i_ext_en(s_xen),
    .i_ext(s_xv), .o_lvl(s_lvl));
  mpfc_line_model i_mpfc_line_model_r (.i_clk(i_clk), .i_out(1'b0),
    .i_oe_n(1'b1), .i_pu(r_pu), .i_pd(r_pd), .i_ext_en(1'b1),
    .i_ext(rx_ext), .o_lvl(r_lvl));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  // expected {out, oe_n, pu, pd}; out is free while the pin is an input
  function automatic logic [7:0] pexp(input int c, input logic v,
                                      input logic [7:0] s, input logic o);
    if (c == 0) return {4'h0, o, 1'b1, s[7], s[6] & ~s[7]};
    if (c == 1 || c == 3) return {6'h0, v, 2'b00};
    return {4'h0, v, 3'b000};
  endfunction

  task automatic t_regs();
    foreach (tv[k]) begin
      rd(8'h2C + 8'(k % 3), d);
      if (k < 3) chk(d, 8'h00);
    end
    rd(8'h10, d);
    chk(d, 8'h00);
    @(posedge i_clk);
    i_otp_trdy <= 8'h84;
    i_otp_srdy <= 8'h40;
    i_otp_data <= 8'hA1;
    i_otp_load <= 1'b1;
    // a write beside the load must lose
    wr(8'h2C, 8'h02);
    @(posedge i_clk);
    i_otp_load <= 1'b0;
    rd(8'h2C, d);
    chk(d, 8'h84);
    @(negedge i_clk);
    chk(o_rdata, 8'h00);
    rd(8'h2D, d);
    chk(d, 8'h40);
    rd(8'h2E, d);
    chk(d, 8'hA1);
  endtask
  task automatic t_pins();
    for (int v = 0; v < 2; v++) begin
      @(posedge i_clk);
      i_dtr <= ~v[0];
      wr(8'h2D, 8'h00);
      wr(8'h41, {6'h0, v[0], v[0]});
      foreach (tv[k]) begin
        wr(8'h2C, tv[k]);
        chk({4'h0, t_out, t_oe, t_pu, t_pd},
            pexp(tv[k][2:0], tv[k][2:0] > 2 ? ~v[0] : v[0], tv[k], t_out));
        // modem codes come first, while set-ready is still an input
        if (k < 2) continue;
        wr(8'h2D, tv[k]);
        chk({4'h0, s_out, s_oe, s_pu, s_pd},
            pexp(tv[k][1:0], v[0], tv[k], s_out));
      end
    end
    wr(8'h2C, 8'h00);
  endtask
  task automatic t_data();
    for (int v = 0; v < 2; v++) begin
      @(posedge i_clk);
      i_txd <= v[0];
      foreach (xv[k]) begin
        wr(8'h2E, xv[k]);
        chk({x_out, x_oe, r_pu, r_pd}, {xv[k][0] ? {v[0], 1'b0}
            : {1'b0, v[0]}, xv[k][7], xv[k][6] & ~xv[k][7]});
      end
    end
  endtask
  task automatic t_wake(input logic [7:0] s, input logic g, input int n);
    int c;
    c = 0;
    @(posedge i_clk);
    i_rwk_global <= g;
    i_suspended <= 1'b1;
    wr(8'h2E, s);
    @(posedge i_clk);
    rx_ext <= ~rx_ext;
    repeat (6) begin
      @(negedge i_clk);
      c += int'(o_wake === 1'b1);
    end
    chk(8'(c), 8'(n));
  endtask
  task automatic t_sense(input logic b);
    @(posedge i_clk);
    s_xen <= 1'b1;
    s_xv <= b;
    rx_ext <= b;
    wr(8'h2D, 8'h00);
    wr(8'h2C, 8'h02);
    wr(8'h41, {6'h0, ~b, b});
    repeat (3) @(negedge i_clk);
    chk({7'h0, o_dsr}, {7'h0, b});
    chk({7'h0, o_rxd_sync}, {7'h0, b});
    rd(8'h41, d);
    chk(d, {6'h0, ~b, b});
    rd(8'h40, d);
    chk(d, {5'h0, b, b, b});
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_regs();
    t_pins();
    t_data();
    t_wake(8'h20, 1'b1, 1);
    t_wake(8'h20, 1'b0, 0);
    t_wake(8'h00, 1'b1, 0);
    t_sense(1'b0);
    t_sense(1'b1);
    give_verdict();
  end
endmodule // modem_pin_function_config_tb
`default_nettype wire
